//--- hdl/tuner_i2c_pkg.sv
/*
 * Shared constants for the tuner two-wire slave port: register
 * offsets, status bit positions, counts and reset values.
 * Assumes nothing of its surroundings; imported by no one, used by
 * scoped names only.
 */
package tuner_i2c_pkg;

    // register bank geometry
    localparam int unsigned REG_COUNT  = 26;
    localparam int unsigned IDX_W      = 5;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_W     = IDX_W + BYTE_W;
    localparam logic [7:0]  REG_RESET  = 8'h00;

    // register offsets
    localparam logic [4:0] CHARGE_PUMP_CONTROL       = 5'h00;
    localparam logic [4:0] SYNTH_DIVIDER_LOW         = 5'h01;
    localparam logic [4:0] SYNTH_DIVIDER_HIGH        = 5'h02;
    localparam logic [4:0] TUNING_OFFSET_ONE         = 5'h03;
    localparam logic [4:0] TUNING_OFFSET_TWO         = 5'h04;
    localparam logic [4:0] FREQ_COUNTER_CTRL_A       = 5'h05;
    localparam logic [4:0] FREQ_COUNTER_CTRL_B       = 5'h06;
    localparam logic [4:0] UNUSED_SLOT_A             = 5'h07;
    localparam logic [4:0] SELECTIVITY_FILTER_CTRL   = 5'h08;
    localparam logic [4:0] ADJACENT_CHANNEL_CTRL     = 5'h09;
    localparam logic [4:0] MULTIPATH_CTRL            = 5'h0a;
    localparam logic [4:0] DEVIATION_CTRL            = 5'h0b;
    localparam logic [4:0] SOFT_MUTE_CTRL_A          = 5'h0c;
    localparam logic [4:0] SOFT_MUTE_CTRL_B          = 5'h0d;
    localparam logic [4:0] OSCILLATOR_REFERENCE_CTRL = 5'h0e;
    localparam logic [4:0] GAIN_CONTROL_SETTINGS     = 5'h0f;
    localparam logic [4:0] UNUSED_SLOT_B             = 5'h10;
    localparam logic [4:0] DEMODULATOR_ADJUST        = 5'h11;
    localparam logic [4:0] LEVEL_METER_CTRL          = 5'h12;
    localparam logic [4:0] IF_GAIN_CRYSTAL_ADJUST    = 5'h13;
    localparam logic [4:0] MIXER_TANK_ADJUST         = 5'h14;
    localparam logic [4:0] QUADRATURE_MIXER_ADJUST   = 5'h15;
    localparam logic [4:0] TEST_CONTROL_A            = 5'h16;
    localparam logic [4:0] TEST_CONTROL_B            = 5'h17;
    localparam logic [4:0] TEST_CONTROL_C            = 5'h18;
    localparam logic [4:0] TEST_CONTROL_D            = 5'h19;

    // status byte bit positions
    localparam int unsigned ST_FILTER_ON  = 0;
    localparam int unsigned ST_MID_BW     = 1;
    localparam int unsigned ST_MULTIPATH  = 2;
    localparam int unsigned ST_LOCKED     = 3;
    localparam int unsigned ST_LOW_FIELD  = 4;
    localparam int unsigned ST_ADJACENT   = 5;
    localparam int unsigned ST_STRONG_DEV = 6;
    localparam int unsigned ST_OVERDEV    = 7;

    // bits in one byte on the wire
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // serial state machine, one-hot
    typedef enum logic [8:0] {
        S_IDLE     = 9'h001,
        S_ADDR     = 9'h002,
        S_ADDR_ACK = 9'h004,
        S_SUB      = 9'h008,
        S_SUB_ACK  = 9'h010,
        S_DATA     = 9'h020,
        S_DATA_ACK = 9'h040,
        S_READ     = 9'h080,
        S_IGNORE   = 9'h100
    } serial_state_t;

endpackage

//--- hdl/tuner_i2c_slave_port.sv
/*
 * Two-wire slave port of the tuner: serial engine, write FIFO,
 * control register bank and status readback, plus the FIFO module.
 * Assumes scl and sda arrive asynchronously and are sampled by
 * clk_sys well above the bus rate; the pad resolves open drain.
 */
//////////////////////////////////////////////////////////////////////
// Summary of operation
// - data changes only while clock is low
// - watch for start, ignore bus until then
// - stop ends transfer and returns to idle
// - receiver pulls data low on ninth pulse
// - data sampled on rising clock edge
// - upper six address bits match type code
// - seventh address bit comes from strap
// - address lsb: one reads, zero writes
// - acknowledge matching address, then read or write
// - write: next byte is word address, acknowledged
// - data bytes acknowledged, address auto increments
// - read returns exactly one status byte
// - status low half: filter, bandwidth, multipath, lock
// - status high half: field, adjacent, overdeviations
//////////////////////////////////////////////////////////////////////

// small synchronous FIFO with valid/ready on both sides
module tuner_write_fifo #(
    parameter int unsigned WIDTH = 13,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // full and empty come straight from the occupancy count
    assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset; only counted entries are ever read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

//////////////////////////////////////////////////////////////////////

module tuner_i2c_slave_port #(
    // device type code; value is arbitrary
    parameter logic [5:0] DEVICE_TYPE = 6'h2a
) (
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic         scl_in,
    input  wire logic         sda_in,
    output logic              sda_o,
    output logic              sda_oe_n,
    input  wire logic         addr_strap,
    input  wire logic         narrow_filter_on,
    input  wire logic         narrow_mid_bandwidth_select,
    input  wire logic         multipath_present_flag,
    input  wire logic         synth_locked,
    input  wire logic         below_mute_threshold,
    input  wire logic         adjacent_channel_present,
    input  wire logic         strong_overdeviation,
    input  wire logic         overdeviation,
    input  wire logic         bank_hold,
    output logic      [207:0] reg_bank
);
    localparam int unsigned FW = tuner_i2c_pkg::FIFO_W;

    logic [2:0] scl_sy, sda_sy;
    logic [1:0] strap_sy;
    logic [7:0] stat_m, status_s;
    logic       scl_rise, scl_fall, start_ev, stop_ev, own_strap;

    tuner_i2c_pkg::serial_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d, out_q, out_d;
    logic [4:0] sub_q, sub_d;
    logic       rw_q, rw_d, drive_q, drive_d, push, addr_hit;

    logic          fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [FW-1:0] fifo_out_data;
    logic [207:0]  bank_q, bank_d;
    logic [4:0]    wr_idx;

    //////////////////////////////////////////////////////////////////
    // input synchronisers: stage 0 is read only by stage 1
    always_ff @(posedge clk_sys) begin
        scl_sy   <= {scl_sy[1:0], scl_in};
        sda_sy   <= {sda_sy[1:0], sda_in};
        strap_sy <= {strap_sy[0], addr_strap};
        stat_m   <= {overdeviation, strong_overdeviation,
                     adjacent_channel_present, below_mute_threshold,
                     synth_locked, multipath_present_flag,
                     narrow_mid_bandwidth_select, narrow_filter_on};
        status_s <= stat_m;
    end

    // strap is sampled on every clock, also while reset is held; reset never loads it
    always_ff @(posedge clk_sys) begin
        own_strap <= strap_sy[1];
    end

    // bus events from stages 1 and 2 only
    assign scl_rise = scl_sy[1] && !scl_sy[2];
    assign scl_fall = !scl_sy[1] && scl_sy[2];
    // data moving while clock high is framing, never data
    assign start_ev = scl_sy[1] && scl_sy[2] && !sda_sy[1] && sda_sy[2];
    assign stop_ev  = scl_sy[1] && scl_sy[2] && sda_sy[1] && !sda_sy[2];
    // address byte against type code and strap, lsb is direction
    assign addr_hit = (shift_q[7:1] == {DEVICE_TYPE, own_strap});

    // open drain: the line is only ever pulled low; clock never driven
    assign sda_o    = 1'b0;
    assign sda_oe_n = !drive_q;

    //////////////////////////////////////////////////////////////////
    // serial engine: bytes shift in on scl rise, line moves on scl fall
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        out_d   = out_q;
        sub_d   = sub_q;
        rw_d    = rw_q;
        drive_d = drive_q;
        push    = 1'b0;
        if (start_ev) begin
            state_d = tuner_i2c_pkg::S_ADDR;
            cnt_d   = '0;
            drive_d = 1'b0;
        end else if (stop_ev) begin
            state_d = tuner_i2c_pkg::S_IDLE;
            drive_d = 1'b0;
        end else begin
            case (state_q)
                tuner_i2c_pkg::S_ADDR,
                tuner_i2c_pkg::S_SUB,
                tuner_i2c_pkg::S_DATA: begin
                    if (scl_rise && cnt_q < tuner_i2c_pkg::BITS_PER_BYTE) begin
                        shift_d = {shift_q[6:0], sda_sy[1]};
                        cnt_d   = cnt_q + 1'b1;
                    end
                    if (scl_fall && cnt_q == tuner_i2c_pkg::BITS_PER_BYTE) begin
                        cnt_d = '0;
                        if (state_q == tuner_i2c_pkg::S_ADDR) begin
                            if (addr_hit) begin
                                state_d = tuner_i2c_pkg::S_ADDR_ACK;
                                drive_d = 1'b1;
                                rw_d    = shift_q[0];
                            end else begin
                                state_d = tuner_i2c_pkg::S_IGNORE;
                            end
                        end else if (state_q == tuner_i2c_pkg::S_SUB) begin
                            sub_d   = shift_q[4:0];
                            state_d = tuner_i2c_pkg::S_SUB_ACK;
                            drive_d = 1'b1;
                        end else if (fifo_in_ready) begin
                            push    = 1'b1;
                            sub_d   = sub_q + 1'b1;
                            state_d = tuner_i2c_pkg::S_DATA_ACK;
                            drive_d = 1'b1;
                        end else begin
                            // full FIFO: refuse the byte with a nack
                            state_d = tuner_i2c_pkg::S_IGNORE;
                        end
                    end
                end
                tuner_i2c_pkg::S_ADDR_ACK: begin
                    if (scl_fall && rw_q) begin
                        state_d = tuner_i2c_pkg::S_READ;
                        out_d   = status_s;
                        drive_d = !status_s[7];
                        cnt_d   = 4'h1;
                    end else if (scl_fall) begin
                        state_d = tuner_i2c_pkg::S_SUB;
                        drive_d = 1'b0;
                    end
                end
                tuner_i2c_pkg::S_SUB_ACK,
                tuner_i2c_pkg::S_DATA_ACK: begin
                    if (scl_fall) begin
                        state_d = tuner_i2c_pkg::S_DATA;
                        drive_d = 1'b0;
                    end
                end
                tuner_i2c_pkg::S_READ: begin
                    if (scl_fall && cnt_q == tuner_i2c_pkg::BITS_PER_BYTE) begin
                        // one byte only; master's ack slot left free
                        state_d = tuner_i2c_pkg::S_IGNORE;
                        drive_d = 1'b0;
                    end else if (scl_fall) begin
                        out_d   = {out_q[6:0], 1'b0};
                        drive_d = !out_q[6];
                        cnt_d   = cnt_q + 1'b1;
                    end
                end
                default: begin
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= tuner_i2c_pkg::S_IDLE;
            cnt_q   <= '0;
            shift_q <= '0;
            out_q   <= '0;
            sub_q   <= '0;
            rw_q    <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            out_q   <= out_d;
            sub_q   <= sub_d;
            rw_q    <= rw_d;
            drive_q <= drive_d;
        end
    end

    //////////////////////////////////////////////////////////////////
    // write FIFO decouples the bus from a stalled register bank
    tuner_write_fifo #(
        .WIDTH (FW),
        .DEPTH (tuner_i2c_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({sub_q, shift_q}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = !bank_hold;
    assign wr_idx         = fifo_out_data[FW-1:8];

    // register bank; void slots and indices past the end are dropped
    always_comb begin
        bank_d = bank_q;
        if (fifo_out_valid && fifo_out_ready
            && wr_idx != tuner_i2c_pkg::UNUSED_SLOT_A
            && wr_idx != tuner_i2c_pkg::UNUSED_SLOT_B
            && 32'(wr_idx) < tuner_i2c_pkg::REG_COUNT) begin
            bank_d[wr_idx*8 +: 8] = fifo_out_data[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bank_q <= {tuner_i2c_pkg::REG_COUNT{tuner_i2c_pkg::REG_RESET}};
        end else begin
            bank_q <= bank_d;
        end
    end

    assign reg_bank = bank_q;

    //////////////////////////////////////////////////////////////////
    // checks
    property p_start_enters_addr;
        @(posedge clk_sys) disable iff (sys_rst)
        start_ev |=> state_q == tuner_i2c_pkg::S_ADDR && !drive_q;
    endproperty
    a_start_enters_addr: assert property (p_start_enters_addr)
        else $error("start did not enter address phase");

    property p_stop_idles;
        @(posedge clk_sys) disable iff (sys_rst)
        stop_ev && !start_ev |=> state_q == tuner_i2c_pkg::S_IDLE
            ##1 sda_oe_n;
    endproperty
    a_stop_idles: assert property (p_stop_idles)
        else $error("stop did not return to idle");

    property p_ack_held;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == tuner_i2c_pkg::S_SUB_ACK && !scl_fall
            && !start_ev && !stop_ev
            |=> state_q == tuner_i2c_pkg::S_SUB_ACK && !sda_oe_n;
    endproperty
    a_ack_held: assert property (p_ack_held)
        else $error("ack not held through ninth clock");

    property p_sample_rise;
        @(posedge clk_sys) disable iff (sys_rst)
        scl_rise && !start_ev && !stop_ev && cnt_q < 4'h8
            && state_q == tuner_i2c_pkg::S_DATA
            |=> shift_q[0] == $past(sda_sy[1]);
    endproperty
    a_sample_rise: assert property (p_sample_rise)
        else $error("bit not sampled on clock rise");

    property p_addr_match;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == tuner_i2c_pkg::S_ADDR && scl_fall && cnt_q == 4'h8
            && !start_ev && !stop_ev
            && shift_q[7:1] == {DEVICE_TYPE, own_strap}
            |=> state_q == tuner_i2c_pkg::S_ADDR_ACK && !sda_oe_n;
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("matching address not acknowledged");

    property p_mismatch_quiet;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == tuner_i2c_pkg::S_IGNORE |-> sda_oe_n;
    endproperty
    a_mismatch_quiet: assert property (p_mismatch_quiet)
        else $error("line driven while ignoring bus");

    property p_read_dir;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == tuner_i2c_pkg::S_ADDR_ACK && scl_fall && rw_q
            && !start_ev && !stop_ev
            |=> state_q == tuner_i2c_pkg::S_READ
                && out_q == $past(status_s)
                && sda_oe_n == $past(status_s[7]);
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("read did not load status byte");

    property p_sub_incr;
        @(posedge clk_sys) disable iff (sys_rst)
        push |=> sub_q == $past(sub_q) + 5'h01;
    endproperty
    a_sub_incr: assert property (p_sub_incr)
        else $error("word address did not advance");

    property p_void_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        fifo_out_valid && fifo_out_ready
            && wr_idx == tuner_i2c_pkg::UNUSED_SLOT_B
            |=> $stable(reg_bank);
    endproperty
    a_void_slot: assert property (p_void_slot)
        else $error("write to void slot changed bank");

    c_write: cover property (@(posedge clk_sys) push);
    c_read: cover property (@(posedge clk_sys)
        state_q == tuner_i2c_pkg::S_READ);
    c_ignore: cover property (@(posedge clk_sys)
        state_q == tuner_i2c_pkg::S_IGNORE);
endmodule

//--- tb/bus_master.sv
/*
 * Behavioural two-wire bus master that drives the tuner port.
 * Assumes the bench resolves the open-drain data wire with a
 * pull-up and feeds the resolved level back on sda_in.
 */
module bus_master (
    input  wire logic clk_sys,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus: clock stands high, data released to the pull-up
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // wait n system clocks, then move just past the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one pulse: data set while clock low, sampled mid-high
    task automatic bit_x(input logic b, output logic s);
        // idle bus has the clock high: lower it first so a zero bit
        // cannot be mistaken for a start condition
        if (scl) begin
            scl = 1'b0;
            step(4);
        end
        sda_drv = b;
        step(4);
        scl = 1'b1;
        step(4);
        s = sda_in;
        step(4);
        scl = 1'b0;
        step(4);
    endtask

    // data falls while clock high; also serves as repeated start
    task automatic start_c;
        sda_drv = 1'b1;
        step(4);
        scl = 1'b1;
        step(4);
        sda_drv = 1'b0;
        step(4);
        scl = 1'b0;
        step(4);
    endtask

    // data rises while clock high, bus left idle
    task automatic stop_c;
        sda_drv = 1'b0;
        step(4);
        scl = 1'b1;
        step(4);
        sda_drv = 1'b1;
        step(8);
    endtask

    // eight bits msb first, then the ninth pulse
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], s);
            rx[i] = s;
        end
        bit_x(ack_in, ack);
    endtask
endmodule

//--- tb/tb_tuner_i2c_slave_port.sv
/*
 * Self-checking bench for the tuner two-wire slave port.
 * Assumes bus_master as the far side and a pull-up on data.
 */
module tb_tuner_i2c_slave_port;
    timeunit 1ns;
    timeprecision 100ps;

    // type code handed to the port; value is arbitrary
    localparam logic [5:0] TYPE_CODE = 6'h2a;
    localparam logic [7:0] ADDR_W    = {TYPE_CODE, 2'b00};
    localparam logic [7:0] ADDR_R    = {TYPE_CODE, 2'b01};
    localparam int         LIMIT     = 20000;

    logic         clk_sys    = 1'b0;
    logic         sys_rst    = 1'b1;
    logic         addr_strap = 1'b0;
    logic         bank_hold  = 1'b0;
    logic [7:0]   status     = 8'h00;
    logic         scl;
    logic         sda_drv;
    logic         sda_o;
    logic         sda_oe_n;
    logic [207:0] reg_bank;
    wire          sda_w;
    int           fail_count = 0;
    int           samples_checked = 0;
    int           cycles = 0;

    always #5 clk_sys = ~clk_sys;

    // open-drain wire: anyone pulling low wins
    assign sda_w = sda_drv & (sda_oe_n | sda_o);

    tuner_i2c_slave_port #(.DEVICE_TYPE(TYPE_CODE)) tuner_i2c_slave_port_i (
        .clk_sys                     (clk_sys),
        .sys_rst                     (sys_rst),
        .scl_in                      (scl),
        .sda_in                      (sda_w),
        .sda_o                       (sda_o),
        .sda_oe_n                    (sda_oe_n),
        .addr_strap                  (addr_strap),
        .narrow_filter_on            (status[0]),
        .narrow_mid_bandwidth_select (status[1]),
        .multipath_present_flag      (status[2]),
        .synth_locked                (status[3]),
        .below_mute_threshold        (status[4]),
        .adjacent_channel_present    (status[5]),
        .strong_overdeviation        (status[6]),
        .overdeviation               (status[7]),
        .bank_hold                   (bank_hold),
        .reg_bank                    (reg_bank)
    );

    bus_master bus_master_i (
        .clk_sys (clk_sys),
        .sda_in  (sda_w),
        .scl     (scl),
        .sda_drv (sda_drv)
    );

    //////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp,
                     seen);
        end
    endtask

    function automatic logic [7:0] regv(input int k);
        return reg_bank[8*k +: 8];
    endfunction

    // one written byte; exp_ack 0 means the port must pull low
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic       ack;
        bus_master_i.xfer(b, 1'b1, rx, ack);
        check("ack", {7'h00, ack}, {7'h00, exp_ack});
    endtask

    task automatic settle;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked,
                 fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int k = 0; k < 26; k++)
            check("reset", regv(k), 8'h00);
        check("released", {7'h00, sda_oe_n}, 8'h01);
        $display("test reset done");
    endtask

    // burst write across inert slot 7
    task automatic t_write;
        bus_master_i.start_c();
        send(ADDR_W, 1'b0);
        send(8'h05, 1'b0);
        send(8'h3c, 1'b0);
        send(8'h81, 1'b0);
        send(8'h77, 1'b0);
        send(8'he4, 1'b0);
        bus_master_i.stop_c();
        check("r5", regv(5), 8'h3c);
        check("r6", regv(6), 8'h81);
        check("r7", regv(7), 8'h00);
        check("r8", regv(8), 8'he4);
        $display("test write done");
    endtask

    // fill the fifo while the bank stalls, index wraps past 31
    task automatic t_fifo;
        bank_hold = 1'b1;
        bus_master_i.start_c();
        send(ADDR_W, 1'b0);
        send(8'h1c, 1'b0);
        for (int i = 0; i < 8; i++)
            send(8'h40 + 8'(i), 1'b0);
        send(8'hee, 1'b1);
        bus_master_i.stop_c();
        check("held", regv(0), 8'h00);
        bank_hold = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        for (int k = 0; k < 4; k++)
            check("wrap", regv(k), 8'h44 + 8'(k));
        $display("test fifo done");
    endtask

    // address compare against type code and strap
    task automatic t_match;
        addr_strap = 1'b1;
        settle();
        bus_master_i.start_c();
        send(ADDR_W, 1'b1);
        send(8'h0c, 1'b1);
        send(8'h99, 1'b1);
        bus_master_i.start_c();
        send({6'h2b, 2'b10}, 1'b1);
        bus_master_i.stop_c();
        check("r12", regv(12), 8'h00);
        bus_master_i.start_c();
        send({TYPE_CODE, 2'b10}, 1'b0);
        send(8'h0c, 1'b0);
        send(8'h5d, 1'b0);
        bus_master_i.stop_c();
        check("r12", regv(12), 8'h5d);
        addr_strap = 1'b0;
        settle();
        $display("test match done");
    endtask

    // one status byte per read, complementary patterns
    task automatic t_read;
        logic [7:0] rx;
        logic       ack;
        for (int j = 0; j < 2; j++) begin
            status = j ? 8'h5a : 8'ha5;
            settle();
            bus_master_i.start_c();
            send(ADDR_R, 1'b0);
            bus_master_i.xfer(8'hff, 1'b0, rx, ack);
            check("status", rx, j ? 8'h5a : 8'ha5);
            bus_master_i.xfer(8'hff, 1'b1, rx, ack);
            check("extra", rx, 8'hff);
            bus_master_i.stop_c();
        end
        $display("test read done");
    endtask

    // traffic without start, after stop, and a repeated start
    task automatic t_idle;
        send(ADDR_W, 1'b1);
        send(8'h09, 1'b1);
        bus_master_i.start_c();
        send(ADDR_W, 1'b0);
        send(8'h09, 1'b0);
        bus_master_i.stop_c();
        send(8'h66, 1'b1);
        bus_master_i.start_c();
        send(ADDR_W, 1'b0);
        send(8'h0d, 1'b0);
        bus_master_i.start_c();
        send(ADDR_W, 1'b0);
        send(8'h0e, 1'b0);
        send(8'h21, 1'b0);
        send(8'h3b, 1'b0);
        send(8'hc3, 1'b0);
        send(8'h96, 1'b0);
        bus_master_i.stop_c();
        check("r9", regv(9), 8'h00);
        check("r13", regv(13), 8'h00);
        check("r14", regv(14), 8'h21);
        check("r15", regv(15), 8'h3b);
        check("r16", regv(16), 8'h00);
        check("r17", regv(17), 8'h96);
        $display("test idle done");
    endtask

    //////////////////////////////////////////////////////////////////
    // hang guard: a run well past the expected length is a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            $display("timeout after %0d cycles", cycles);
            summarize();
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        settle();
        t_reset();
        t_write();
        t_fifo();
        t_match();
        t_read();
        t_idle();
        summarize();
    end
endmodule
